/* nvm_cfg_loader.sv */
// board setup loader: register slave plus serial memory sequencer
`timescale 1ns/1ps
module nvm_cfg_loader
   import nvm_cfg_pkg::*;
#(
   parameter int SK_HALF = SK_HALF_CYC
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [2:0]  board_select_straps,
   input  wire logic        nvm_present_strap,
   output logic             nvm_cs,
   output logic             nvm_sk,
   output logic             nvm_di,
   input  wire logic        nvm_do,
   output logic [15:0]      cfg_word,
   output logic [15:0]      base_word,
   output logic [47:0]      station_addr
);

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   // data-out crosses two flops, so a half period under three cycles
   // would sample the bit before the fall that launched it
   if (SK_HALF < 3 || SK_HALF > 32) begin : g_bad_sk
      $error("SK_HALF must lie in 3..32");
   end

   localparam logic [4:0] SK_LAST = 5'(SK_HALF - 1);

   // ------------------------------------------------------------
   // whole module state
   // ------------------------------------------------------------
   typedef struct packed {
      seq_st_t     st;      // sequencer state
      nvm_op_t     op;      // operation in progress
      logic [2:0]  step;    // word index within operation
      logic [1:0]  boot;    // settle count after reset
      logic [4:0]  div;     // serial clock divider
      logic        sk;      // serial clock
      logic        cs;      // chip select
      logic        di;      // data to memory
      logic [24:0] sh;      // outgoing frame
      logic [4:0]  cnt;     // rising edges sent
      logic [4:0]  nbits;   // frame length
      logic [15:0] rx;      // incoming data
      logic [1:0]  do_s;    // data-out synchroniser
      logic [2:0]  ios_m;   // strap synchroniser stage one
      logic [2:0]  ios_s;   // strap synchroniser stage two
      logic        pres_m;
      logic        pres_s;
      logic        sel;     // target select
      logic [15:0] cfg;
      logic [15:0] base;
      logic [47:0] ia;
      logic [15:0] ptr;
      logic [15:0] gp;
      logic        aw_got;  // write address held
      logic [7:0]  aw_addr;
      logic        w_got;   // write data held
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        ar_got;  // read address held
      logic [7:0]  ar_addr;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } state_t;

   localparam state_t S_RST = '{st: ST_BOOT, op: OP_LOAD_NORM, cfg: CFG_RST,
                                base: BASE_RST, ia: IA_RST, default: '0};

   state_t q;   // registered state
   state_t d;   // next state

   logic        busy;     // an operation or the boot load runs
   logic        tick;     // half period of serial clock elapsed
   logic [1:0]  opc;      // opcode of current step
   logic [5:0]  wadr;     // word address of current step
   logic [15:0] wval;     // word written in current step
   logic [2:0]  last;     // final step of current operation
   logic [2:0]  first;    // opening step of a normal load
   logic        is_read;  // current step reads a word

   // merge byte lanes into a 16-bit field
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   // ------------------------------------------------------------
   // step decode: what each step of an operation does
   // ------------------------------------------------------------
   always_comb begin
      opc   = OPC_READ;
      wadr  = '0;
      wval  = '0;
      last  = 3'h0;
      first = (q.ios_s == IOS_NOLOAD) ? 3'h2 : 3'h0;
      unique case (q.op)
         OP_LOAD_NORM: begin
            last = 3'h4;
            if (q.step < 3'h2) begin
               wadr = {1'b0, q.ios_s, 1'b0, q.step[0]};
            end else begin
               wadr = IA_WORD0 + 6'(q.step - 3'h2);
            end
         end
         OP_STORE_NORM: begin
            last = 3'h2;
            if (q.step == 3'h0) begin
               opc  = OPC_EWEN;
               wadr = ADR_EWEN;
            end else begin
               opc  = OPC_WRITE;
               wadr = {1'b0, q.ios_s, 1'b0, ~q.step[0]};
               wval = q.step[0] ? q.cfg : q.base;
            end
         end
         OP_LOAD_GP: begin
            wadr = q.ptr[5:0];
         end
         OP_STORE_GP: begin
            last = 3'h1;
            if (q.step == 3'h0) begin
               opc  = OPC_EWEN;
               wadr = ADR_EWEN;
            end else begin
               opc  = OPC_WRITE;
               wadr = q.ptr[5:0];
               wval = q.gp;
            end
         end
      endcase
      is_read = (opc == OPC_READ);
   end

   assign busy = (q.st != ST_IDLE);
   assign tick = (q.div == SK_LAST);

   // ------------------------------------------------------------
   // next-state logic: synchronisers, sequencer, register slave
   // ------------------------------------------------------------
   always_comb begin
      d        = q;
      // two-stage synchronisers, second stage only is read
      d.do_s   = {q.do_s[0], nvm_do};
      d.ios_m  = board_select_straps;
      d.ios_s  = q.ios_m;
      d.pres_m = nvm_present_strap;
      d.pres_s = q.pres_m;
      d.div    = tick ? 5'h00 : q.div + 5'h01;

      // serial sequencer
      unique case (q.st)
         ST_BOOT: begin
            d.boot = q.boot + 2'h1;
            if (q.boot == BOOT_LAST) begin
               if (q.pres_s) begin
                  d.st   = ST_START;
                  d.op   = OP_LOAD_NORM;
                  d.step = first;
               end else begin
                  d.st = ST_IDLE; // defaults kept
               end
            end
         end
         ST_IDLE: begin
            d.cs = 1'b0;
            d.sk = 1'b0;
         end
         ST_START: begin
            // frame: start, opcode, six address bits, then data except in an enable frame
            if (tick) begin
               d.cs    = 1'b1;
               d.di    = 1'b1;
               d.sh    = {opc, wadr, wval, 1'b0};
               d.cnt   = 5'h00;
               d.nbits = (opc == OPC_EWEN) ? BITS_CMD : BITS_FULL;
               d.st    = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (tick) begin
               if (!q.sk) begin
                  d.sk  = 1'b1;
                  d.rx  = {q.rx[14:0], q.do_s[1]};
                  d.cnt = q.cnt + 5'h01;
               end else begin
                  d.sk = 1'b0;
                  if (q.cnt == q.nbits) begin
                     d.cs = 1'b0;
                     d.di = 1'b0;
                     d.st = ST_GAP;
                  end else begin
                     d.di = q.sh[24];
                     d.sh = {q.sh[23:0], 1'b0};
                  end
               end
            end
         end
         ST_GAP: begin
            // select dropped one half period before a busy poll, two after a read or enable frame
            if (tick) begin
               if (opc == OPC_WRITE) begin
                  d.cs = 1'b1;
                  d.st = ST_POLL;
               end else begin
                  d.st = ST_NEXT;
               end
            end
         end
         ST_POLL: begin
            // memory holds data-out low until programming ends
            if (tick && q.do_s[1]) begin
               d.cs = 1'b0;
               d.st = ST_NEXT;
            end
         end
         ST_NEXT: begin
            if (is_read) begin
               if (q.op == OP_LOAD_GP) begin
                  d.gp = q.rx;
               end else begin
                  unique case (q.step)
                     3'h0:    d.cfg = q.rx;
                     3'h1:    d.base = q.rx;
                     3'h2:    d.ia[15:0] = q.rx;
                     3'h3:    d.ia[31:16] = q.rx;
                     default: d.ia[47:32] = q.rx;
                  endcase
               end
            end
            if (q.step == last) begin
               d.st = ST_IDLE;
            end else begin
               d.step = q.step + 3'h1;
               d.st   = ST_START;
            end
         end
         default: d.st = ST_IDLE;
      endcase

      // write channel capture
      if (s_axi_awvalid && q.awready) begin
         d.aw_got  = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end

      // write execution waits for the sequencer to go idle
      if (q.aw_got && q.w_got && !q.bvalid && !busy) begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = RESP_OKAY;
         unique case (q.aw_addr)
            OFS_CTRL: begin
               if (q.wstrb[0]) begin
                  d.sel = q.wdata[BIT_SEL];
                  // start only with memory fitted; load wins over store
                  if (q.pres_s && (q.wdata[BIT_RELOAD] || q.wdata[BIT_STORE])) begin
                     d.st = ST_START;
                     if (q.wdata[BIT_RELOAD]) begin
                        d.op   = q.wdata[BIT_SEL] ? OP_LOAD_GP : OP_LOAD_NORM;
                        d.step = q.wdata[BIT_SEL] ? 3'h0 : first;
                     end else begin
                        d.op   = q.wdata[BIT_SEL] ? OP_STORE_GP : OP_STORE_NORM;
                        d.step = 3'h0;
                     end
                  end
               end
            end
            OFS_CFG:  d.cfg = merge16(q.cfg, q.wdata, q.wstrb);
            OFS_BASE: d.base = merge16(q.base, q.wdata, q.wstrb);
            OFS_IA01: d.ia[15:0] = merge16(q.ia[15:0], q.wdata, q.wstrb);
            OFS_IA23: d.ia[31:16] = merge16(q.ia[31:16], q.wdata, q.wstrb);
            OFS_IA45: d.ia[47:32] = merge16(q.ia[47:32], q.wdata, q.wstrb);
            OFS_PTR:  d.ptr = merge16(q.ptr, q.wdata, q.wstrb);
            OFS_GP:   d.gp = merge16(q.gp, q.wdata, q.wstrb);
            default:  d.bresp = RESP_SLVERR;
         endcase
      end

      // read capture and execution; control word readable while busy
      if (s_axi_arvalid && q.arready) begin
         d.ar_got  = 1'b1;
         d.ar_addr = s_axi_araddr;
      end
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (q.ar_got && !q.rvalid && (!busy || q.ar_addr == OFS_CTRL)) begin
         d.ar_got = 1'b0;
         d.rvalid = 1'b1;
         d.rresp  = RESP_OKAY;
         d.rdata  = 32'h0000_0000;
         unique case (q.ar_addr)
            OFS_CTRL: d.rdata[2:0] = {busy, busy, q.sel};
            OFS_CFG:  d.rdata[15:0] = q.cfg;
            OFS_BASE: d.rdata[15:0] = q.base;
            OFS_IA01: d.rdata[15:0] = q.ia[15:0];
            OFS_IA23: d.rdata[15:0] = q.ia[31:16];
            OFS_IA45: d.rdata[15:0] = q.ia[47:32];
            OFS_PTR:  d.rdata[15:0] = q.ptr;
            OFS_GP:   d.rdata[15:0] = q.gp;
            default:  d.rresp = RESP_SLVERR;
         endcase
      end

      // one transfer of each kind outstanding
      d.awready = !d.aw_got && !d.bvalid;
      d.wready  = !d.w_got && !d.bvalid;
      d.arready = !d.ar_got && !d.rvalid;
   end

   // ------------------------------------------------------------
   // state register, synchronous reset
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= S_RST;
      end else begin
         q <= d;
      end
   end

   assign s_axi_awready = q.awready;
   assign s_axi_wready  = q.wready;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;
   assign nvm_cs        = q.cs;
   assign nvm_sk        = q.sk;
   assign nvm_di        = q.di;
   assign cfg_word      = q.cfg;
   assign base_word     = q.base;
   assign station_addr  = q.ia;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_frame_open;
      $rose(q.cs) && q.st == ST_SHIFT;
   endsequence

   chk_boot_load: assert property (
      q.st == ST_BOOT && q.boot == BOOT_LAST && q.pres_s |=> q.st == ST_START)
      else $error("boot load not started");
   chk_setup_addr: assert property (
      q.st == ST_SHIFT && q.op == OP_LOAD_NORM && q.step < 3'h2 && q.cnt == 5'h00
      |-> q.sh[22:17] == {1'b0, q.ios_s, 2'b00} + 6'(q.step))
      else $error("setup word address wrong");
   chk_ia_addr: assert property (
      q.st == ST_START && q.op == OP_LOAD_NORM && q.step == 3'h3 |-> wadr == 6'h21)
      else $error("station address word wrong");
   chk_strap_seven: assert property (
      q.st == ST_START && q.op == OP_LOAD_NORM && q.ios_s == IOS_NOLOAD
      |-> q.step >= 3'h2)
      else $error("setup words loaded under strap seven");
   chk_frame_start: assert property (
      s_frame_open |-> nvm_di && q.cnt == 5'h00 ##1 $stable(nvm_cs)[*3])
      else $error("frame start bit missing");
   chk_sk_rate: assert property (
      $changed(q.sk) |-> q.div == 5'h00 ##1 $stable(q.sk)[*2])
      else $error("serial clock half period wrong");
   chk_busy_bits: assert property (
      busy && q.ar_got && !q.rvalid && q.ar_addr == OFS_CTRL |=> s_axi_rdata[2:1] == 2'b11)
      else $error("busy bits not read as one");
   chk_write_blocked: assert property (
      $rose(s_axi_bvalid) |-> $past(q.st) == ST_IDLE)
      else $error("write answered while busy");
   chk_no_memory: assert property (
      !q.pres_s && q.st == ST_IDLE |=> q.st == ST_IDLE || $past(q.pres_s) != q.pres_s)
      else $error("memory used without strap");
   chk_sel_kept: assert property (
      q.st == ST_NEXT |=> $stable(q.sel))
      else $error("select bit changed by load");
   chk_gp_addr: assert property (
      q.st == ST_SHIFT && q.op == OP_LOAD_GP && q.cnt == 5'h00
      |-> q.sh[24:23] == OPC_READ && q.sh[22:17] == q.ptr[5:0])
      else $error("pointer not used");

endmodule

/* nvm_cfg_pkg.sv */
// constants and types for the board setup loader
// Function
// - load setup words automatically after hardware reset
// - setup words at strap times four, plus one
// - station address from words 20h-22h, low first
// - strap seven loads station address only
// - all straps high keeps default base value
// - memory is 64 sixteen-bit words, word access
// - select clear: load refreshes setup and address
// - select clear: store writes setup words back
// - three control bits never saved or restored
// - select set: load copies pointed word out
// - select set: store writes general word there
// - busy reads both load and store as one
// - other accesses wait while an operation runs
// - strap low: never touch memory, keep defaults
package nvm_cfg_pkg;

   // ------------------------------------------------------------
   // register map, byte addresses on the register bus
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00; // control_word_reg
   localparam logic [7:0] OFS_CFG  = 8'h04; // configuration word
   localparam logic [7:0] OFS_BASE = 8'h08; // base word
   localparam logic [7:0] OFS_IA01 = 8'h0C; // station_addr_bytes_lo
   localparam logic [7:0] OFS_IA23 = 8'h10; // station address bytes 2-3
   localparam logic [7:0] OFS_IA45 = 8'h14; // station address bytes 4-5
   localparam logic [7:0] OFS_PTR  = 8'h18; // pointer word
   localparam logic [7:0] OFS_GP   = 8'h1C; // general purpose word

   // control word fields
   localparam int BIT_SEL    = 0; // target select
   localparam int BIT_RELOAD = 1; // load request / busy
   localparam int BIT_STORE  = 2; // store request / busy

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [15:0] CFG_RST  = 16'h0000;
   localparam logic [15:0] BASE_RST = 16'h0000; // fixed default base
   localparam logic [47:0] IA_RST   = 48'h0000_0000_0000;

   // ------------------------------------------------------------
   // memory layout and serial frame
   // ------------------------------------------------------------
   localparam logic [5:0] IA_WORD0   = 6'h20; // first station address word
   localparam logic [2:0] IOS_NOLOAD = 3'h7;  // strap code for defaults
   localparam logic [1:0] OPC_READ   = 2'h2;
   localparam logic [1:0] OPC_WRITE  = 2'h1;
   localparam logic [1:0] OPC_EWEN   = 2'h0;
   localparam logic [5:0] ADR_EWEN   = 6'h30;
   localparam logic [4:0] BITS_CMD   = 5'h09; // start, opcode, address
   localparam logic [4:0] BITS_FULL  = 5'h19; // command plus 16 data bits

   // ------------------------------------------------------------
   // timing, 40 MHz clock
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 25000;
   localparam int SK_HALF_NS    = 500;   // least half period of serial clock
   localparam int SK_HALF_CYC   = (SK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [1:0] BOOT_LAST = 2'h3; // strap synchroniser settle

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_BOOT  = 3'b000,
      ST_IDLE  = 3'b001,
      ST_START = 3'b010,
      ST_SHIFT = 3'b011,
      ST_GAP   = 3'b100,
      ST_POLL  = 3'b101,
      ST_NEXT  = 3'b110
   } seq_st_t;

   typedef enum logic [1:0] {
      OP_LOAD_NORM  = 2'b00,
      OP_STORE_NORM = 2'b01,
      OP_LOAD_GP    = 2'b10,
      OP_STORE_GP   = 2'b11
   } nvm_op_t;

endpackage

/* nvm_serial_model.sv */
// serial three-wire memory model, 64 words of 16 bits
`timescale 1ns/1ps
module nvm_serial_model #(
   parameter int BUSY_NS = 500 // self-timed write length
) (
   input  wire logic nvm_cs,
   input  wire logic nvm_sk,
   input  wire logic nvm_di,
   output logic      nvm_do
);
   // ------------------------------------------------
   // storage and frame state
   // ------------------------------------------------
   logic [15:0] mem [64];
   logic [24:0] sr;              // bits shifted in
   int          n;               // rises in this frame
   logic [1:0]  op_q;            // latched opcode
   logic [5:0]  adr_q;           // latched word address
   logic        wen_q  = 1'b0;   // writes locked at power up
   logic        busy_q = 1'b0;   // self-timed write running
   logic        dq     = 1'b1;   // read data bit

   // deselected line floats to its pull-up, busy drives low
   assign nvm_do = !nvm_cs ? 1'b1 : busy_q ? 1'b0 : dq;

   // new frame
   always @(posedge nvm_cs) begin
      n = 0;
      dq = 1'b1;
   end

   // shift in on serial clock rise, msb first
   always @(posedge nvm_sk) begin
      if (nvm_cs && !busy_q) begin
         sr = {sr[23:0], nvm_di};
         n++;
         if (n == 9) begin
            op_q  = sr[7:6];
            adr_q = sr[5:0];
            if (sr[8:4] == 5'h13) wen_q = 1'b1; // enable frame
         end
         if (n == 25 && op_q == 2'h1 && wen_q) begin
            mem[adr_q] = sr[15:0];
            busy_q = 1'b1;
            busy_q <= #(BUSY_NS) 1'b0;
         end
      end
   end

   // read data out on serial clock fall
   always @(negedge nvm_sk) begin
      if (nvm_cs && op_q == 2'h2 && n >= 9 && n < 25) dq = mem[adr_q][24 - n];
   end
endmodule

/* test_nvm_cfg_loader.sv */
// self-checking bench for the board setup loader
`timescale 1ns/1ps
module test_nvm_cfg_loader import nvm_cfg_pkg::*;;
   // ------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] rdata, v;
   logic [2:0]  straps = 3'h2;
   logic        present = 1'b1;
   logic        nvm_cs, nvm_sk, nvm_di, nvm_do;
   logic [15:0] cfg_word, base_word;
   logic [47:0] station_addr;
   int          n_errors = 0, n_tests = 0, n_cs = 0, n0;

   always #12.5 clk = ~clk;
   always @(posedge nvm_cs) n_cs++; // frames seen

   nvm_cfg_loader #(.SK_HALF(3)) u_nvm_cfg_loader (
      .clk(clk), .sys_rst(sys_rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .board_select_straps(straps), .nvm_present_strap(present),
      .nvm_cs(nvm_cs), .nvm_sk(nvm_sk), .nvm_di(nvm_di), .nvm_do(nvm_do),
      .cfg_word(cfg_word), .base_word(base_word), .station_addr(station_addr));

   nvm_serial_model u_nvm_serial_model (
      .nvm_cs(nvm_cs), .nvm_sk(nvm_sk), .nvm_di(nvm_di), .nvm_do(nvm_do));

   // ------------------------------------------------
   // bus tasks, each starts one edge after the last
   // ------------------------------------------------
   function automatic logic [15:0] pat(input int i);
      return 16'hC300 + 16'(i);
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int k = 0; k < 4000; k++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      resp = bresp;
      if (!bvalid) n_errors++; // write never answered
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int k = 0; k < 4000; k++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      d = rdata;
      resp = rresp;
      if (!rvalid) n_errors++; // read never answered
   endtask

   // poll control until both busy bits read low
   task automatic poll(output logic [31:0] d);
      for (int i = 0; i < 500; i++) begin
         rd(OFS_CTRL, d);
         if (d[2:1] === 2'b00) break;
      end
      if (d[2:1] !== 2'b00) n_errors++; // operation never ended
   endtask

   task automatic chk(input logic [47:0] s, input logic [47:0] e);
      n_tests++;
      if (s !== e) begin
         n_errors++;
         $display("Error t=%0t seen %h exp %h", $time, s, e);
      end
   endtask

   task automatic rst(input logic [2:0] s, input logic p);
      sys_rst <= 1'b1;
      straps <= s;
      present <= p;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
   endtask

   task close_out;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // ------------------------------------------------
   // test sequence
   // ------------------------------------------------
   initial begin
      for (int i = 0; i < 64; i++) u_nvm_serial_model.mem[i] = pat(i);
      rst(3'h2, 1'b1);
      rd(OFS_CTRL, v);
      chk(v, 32'h0000_0006);
      rd(OFS_CFG, v); // held until the boot load ends
      chk(v, pat(8));
      rd(OFS_BASE, v);
      chk(v, pat(9));
      for (int i = 0; i < 3; i++) begin
         rd(OFS_IA01 + 8'(4 * i), v);
         chk(v, pat(32 + i));
      end
      chk(station_addr, {pat(34), pat(33), pat(32)});
      chk(cfg_word, pat(8));
      $display("test boot done");
      wr(OFS_CFG, 32'h0000_1234);
      wr(OFS_BASE, 32'h0000_5678);
      wr(OFS_CTRL, 32'h0000_0004);
      rd(OFS_CTRL, v);
      chk(v, 32'h0000_0006);
      poll(v);
      chk(u_nvm_serial_model.mem[8], 16'h1234);
      chk(u_nvm_serial_model.mem[9], 16'h5678);
      u_nvm_serial_model.mem[33] = 16'h3C3C;
      wr(OFS_CTRL, 32'h0000_0002);
      rd(OFS_IA23, v);
      chk(v, 16'h3C3C);
      $display("test store done");
      wr(OFS_PTR, 32'h0000_00C5);
      wr(OFS_CTRL, 32'h0000_0003);
      rd(OFS_GP, v); // waits for the copy
      chk(v, pat(5));
      rd(OFS_CTRL, v);
      chk(v, 32'h0000_0001);
      wr(OFS_GP, 32'h0000_BEEF);
      wr(OFS_CTRL, 32'h0000_0005);
      poll(v);
      chk(v, 32'h0000_0001);
      chk(u_nvm_serial_model.mem[5], 16'hBEEF);
      rd(8'h20, v);
      chk(resp, RESP_SLVERR);
      wr(8'h24, 32'h0000_0001);
      chk(resp, RESP_SLVERR);
      $display("test general word done");
      u_nvm_serial_model.mem[32] = 16'h0F0F;
      rst(3'h7, 1'b1);
      rd(OFS_IA01, v);
      chk(v, 16'h0F0F);
      chk(cfg_word, CFG_RST);
      chk(base_word, BASE_RST);
      $display("test strap seven done");
      n0 = n_cs;
      rst(3'h2, 1'b0);
      wr(OFS_CTRL, 32'h0000_0002);
      rd(OFS_CTRL, v);
      chk(v, 32'h0000_0000);
      chk(station_addr, IA_RST);
      chk(cfg_word, CFG_RST);
      chk(n_cs, n0);
      $display("test no memory done");
      close_out;
   end

   // hang guard, far beyond the expected run
   initial begin
      #1_000_000;
      n_errors++;
      close_out;
   end
endmodule
